//--- gdfs_debounce.sv
`timescale 1ns/1ps
module gdfs_debounce #(
   parameter int W = 5
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Level and limit
   input wire logic level,
   input wire logic [W-1:0] limit,
   output logic deb_out
);
   logic [W-1:0] cnt_r;
   logic out_r;

   // Any low cycle restarts the count, so only a steady level passes
   always_ff @(posedge clk_sys) begin
      if (reset || !level) begin
         cnt_r <= '0;
         out_r <= 1'b0;
      end else if (cnt_r >= limit) begin
         out_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   assign deb_out = out_r;
endmodule : gdfs_debounce

//--- gdfs_mcu_model.sv
`timescale 1ns/1ps
module gdfs_mcu_model (
   // Clock
   input wire logic clk_sys,
   // Register port
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      // Stale data must not look valid
      reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask : rd
   // No search loop: the amplifier sign is not modelled here
   task automatic calibrate(input logic [7:0] best);
      wr(8'h30, 8'h01);
      wr(8'h31, best);
      wr(8'h30, 8'h00);
   endtask : calibrate
endmodule : gdfs_mcu_model

//--- gdfs_pkg.sv
package gdfs_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_SAFETY = 8'h05;
   localparam logic [7:0] ADDR_SCP = 8'h0B;
   localparam logic [7:0] ADDR_IRQ_MSK1 = 8'h12;
   localparam logic [7:0] ADDR_IRQ_STAT1 = 8'h13;
   localparam logic [7:0] ADDR_IRQ_MSK2 = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STAT2 = 8'h15;
   localparam logic [7:0] ADDR_OC_THR = 8'h16;
   localparam logic [7:0] ADDR_AMON = 8'h17;
   localparam logic [7:0] ADDR_OC_DEB = 8'h1D;
   localparam logic [7:0] ADDR_CAL = 8'h30;
   localparam logic [7:0] ADDR_TRIM = 8'h31;
   // Reset values
   localparam logic [7:0] RST_SAFETY = 8'h1E;
   localparam logic [1:0] RST_SCP = 2'h0;
   localparam logic [7:0] RST_IRQ = 8'h00;
   localparam logic [5:0] RST_OC_THR = 6'h00;
   localparam logic [7:0] RST_AMON = 8'h80;
   localparam logic [7:0] RST_OC_DEB = 8'h00;
   localparam logic RST_CAL = 1'b0;
   localparam logic [7:0] RST_TRIM = 8'hA4;
   // Writable bit masks
   localparam logic [7:0] MASK_SAFETY = 8'h3F;
   localparam logic [7:0] MASK_AMON = 8'h9F;
   localparam logic [7:0] MASK_OC_DEB = 8'h77;
   localparam logic [7:0] MASK_STAT2 = 8'h8F;
   // Field positions
   localparam int SAF_GATE_UV_LOW = 5;
   localparam int SAF_OC_ON = 4;
   localparam int SAF_VBAT_OV_ON = 3;
   localparam int SAF_GATE_ON = 2;
   localparam int SAF_SUPPLY_OFF = 1;
   localparam int SAF_SHUTDOWN_ON = 0;
   localparam int AMON_BUF_EN = 7;
   localparam int DEB_DIAG_LSB = 4;
   localparam int STAT1_OT = 7;
   localparam int STAT1_OC = 6;
   localparam int STAT2_OC_DIAG = 7;
   localparam int STAT2_VBAT_OV = 3;
   localparam int STAT2_VG_OV = 2;
   localparam int STAT2_VG_UV = 1;
   localparam int STAT2_VCC_UV = 0;
   // Monitor source code range, and the ground code
   localparam logic [3:0] AMON_FIRST_SRC = 4'h2;
   localparam logic [3:0] AMON_LAST_SRC = 4'hA;
   localparam logic [3:0] AMON_GROUND = 4'h0;
   // Timing
   localparam int OC_DEB_SCALE = 4;
   localparam int CLK_PERIOD_PS = 8000;
   localparam int MCU_RST_NS = 1000;
   localparam int MCU_RST_CYC = (MCU_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage : gdfs_pkg

//--- gdfs_supervisor.sv
`timescale 1ns/1ps
// Overview of operation
// - Reaction code 1: after a short circuit all drivers stay off until flag cleared.
// - Reaction code 2: one retry, next short circuit holds drivers off until cleared.
// - Reaction code 3: two retries, then drivers held off until flags cleared.
// - Calibration bit, reset 0, selects calibration mode when 1.
// - In calibration both amplifier inputs are grounded; measurement unavailable.
// - Eight-bit offset trim, reset 0xA4, drives amplifier offset directly.
// - Four-bit monitor select; codes 2 to 10 are sources, others ground.
// - Monitor select bit 7, reset 1, enables output buffer; bits 6 and 5 reserved.
// - Battery over-voltage with its enable forces high sides off until it ends.
// - Gate-supply under or over-voltage with enable forces all FETs off.
// - Logic-supply low or watchdog: FETs off, controller and registers reset.
// - Fault register resets keep status, wake, reset-source and chip control.
// - Debounced over-current with enable: FETs off until current low and flag cleared.
// - Over-temperature reaction per two-bit code: off, regulators off, sleep.
// - Watchdog events react only when watchdog control bit 1 is set.
// - Supply-off bit ignored while shutdown-on-overtemperature is 1.
// - Gate under-voltage threshold select bit, reset 0, picks 6V setting.
// - Six-bit over-current threshold, reset 0, sets comparator level.
// - Over-current debounce lasts four times the field plus zero or one cycles.
// - Diagnostic debounce lasts the diagnostic field plus zero or one cycles.
// - Flags set on failure, cleared by writing 1 only once failure is over.
// - Flags are set even when the failure reaction is disabled.
module gdfs_supervisor
   import gdfs_pkg::*;
#(
   parameter int MCU_RST_CYCLES = MCU_RST_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Analog comparators, asynchronous
   input wire logic oc_cmp,
   input wire logic battery_ov_cmp,
   input wire logic gate_uv_cmp,
   input wire logic gate_ov_cmp,
   input wire logic logic_uv_cmp,
   input wire logic overtemp_cmp,
   // Same-clock events
   input wire logic [5:0] sc_detect,
   input wire logic wd_event,
   input wire logic wd_react_en,
   // Driver and system control
   output logic hs_off,
   output logic ls_off,
   output logic mcu_reset,
   output logic regulators_off,
   output logic bus_disable,
   output logic sleep_req,
   output logic fault_irq_n,
   // Analog configuration
   output logic amp_cal_select,
   output logic amp_inputs_gnd,
   output logic [7:0] amp_offset_trim,
   output logic [3:0] analog_monitor_select,
   output logic analog_monitor_pin_buf_en,
   output logic gate_uv_low_threshold,
   output logic [5:0] overcurrent_threshold,
   // Debounced comparator levels
   output logic oc_fault,
   output logic oc_diag
);
   logic [5:0] cmp_meta_r, cmp_sync_r;
   logic oc_s, vbat_s, vg_uv_s, vg_ov_s, vcc_uv_s, ot_s;
   logic [7:0] safety_r, msk1_r, msk2_r, amon_r, oc_deb_r, trim_r, stat1_r, stat2_r;
   logic [1:0] scp_r, sc_cnt_r;
   logic [5:0] oc_thr_r;
   logic cal_r, oc_latch_r, fault_rst_r, cfg_rst;
   logic hs_off_r, ls_off_r, mcu_reset_r, reg_off_r, bus_dis_r, sleep_r, irq_n_r;
   logic [3:0] amon_eff_r;
   logic [7:0] rdata_r, clr1, clr2, set1, set2;
   logic [7:0] wd_cnt_r;
   logic [4:0] oc_lim;
   logic sc_hold, gate_block, wd_hit, wd_busy, ot_rst, all_off, fault_now;

   // Two flops before any logic sees a comparator
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cmp_meta_r <= 6'h00;
         cmp_sync_r <= 6'h00;
      end else begin
         cmp_meta_r <= {overtemp_cmp, logic_uv_cmp, gate_ov_cmp, gate_uv_cmp,
                        battery_ov_cmp, oc_cmp};
         cmp_sync_r <= cmp_meta_r;
      end
   end
   assign oc_s = cmp_sync_r[0];
   assign vbat_s = cmp_sync_r[1];
   assign vg_uv_s = cmp_sync_r[2];
   assign vg_ov_s = cmp_sync_r[3];
   assign vcc_uv_s = cmp_sync_r[4];
   assign ot_s = cmp_sync_r[5];

   // Over-current debouncers
   assign oc_lim = 5'(oc_deb_r[2:0] * OC_DEB_SCALE);
   gdfs_debounce #(.W(5)) u_oc_deb (
      .clk_sys(clk_sys),
      .reset(cfg_rst),
      .level(oc_s),
      .limit(oc_lim),
      .deb_out(oc_fault)
   );
   gdfs_debounce #(.W(3)) u_oc_diag_deb (
      .clk_sys(clk_sys),
      .reset(cfg_rst),
      .level(oc_s),
      .limit(oc_deb_r[DEB_DIAG_LSB+:3]),
      .deb_out(oc_diag)
   );

   // Fault reactions
   assign wd_hit = wd_event && wd_react_en;
   assign wd_busy = wd_cnt_r != 8'h00;
   assign ot_rst = ot_s && (safety_r[1:0] != 2'h0);
   assign fault_now = vcc_uv_s || ot_rst || wd_hit || wd_busy;
   assign sc_hold = (scp_r != 2'h0) && (sc_cnt_r >= scp_r) && (stat1_r[5:0] != 6'h00);
   assign gate_block = safety_r[SAF_GATE_ON] && (vg_uv_s || vg_ov_s);
   assign all_off = sc_hold || gate_block || fault_now || oc_latch_r || ot_s;
   // Internal registers reset on faults; status flags do not
   assign cfg_rst = reset || fault_rst_r;

   // Controller reset stretch keeps it held long enough to take effect
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wd_cnt_r <= 8'h00;
      end else if (wd_hit) begin
         wd_cnt_r <= 8'(MCU_RST_CYCLES);
      end else if (wd_busy) begin
         wd_cnt_r <= wd_cnt_r - 8'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         hs_off_r <= 1'b1;
         ls_off_r <= 1'b1;
         mcu_reset_r <= 1'b0;
         fault_rst_r <= 1'b0;
         reg_off_r <= 1'b0;
         bus_dis_r <= 1'b0;
         sleep_r <= 1'b0;
      end else begin
         hs_off_r <= all_off || (safety_r[SAF_VBAT_OV_ON] && vbat_s);
         ls_off_r <= all_off;
         mcu_reset_r <= fault_now;
         fault_rst_r <= fault_now;
         reg_off_r <= ot_rst;
         bus_dis_r <= ot_s;
         sleep_r <= ot_s && safety_r[SAF_SHUTDOWN_ON];
      end
   end

   // Short-circuit retry count
   always_ff @(posedge clk_sys) begin
      if (cfg_rst) begin
         sc_cnt_r <= 2'h0;
      end else if (|sc_detect) begin
         if (scp_r != 2'h0 && sc_cnt_r < scp_r) begin
            sc_cnt_r <= sc_cnt_r + 2'h1;
         end
      end else if (stat1_r[5:0] == 6'h00) begin
         sc_cnt_r <= 2'h0;
      end
   end

   // Over-current latch: needs the current low and the flag gone
   always_ff @(posedge clk_sys) begin
      if (cfg_rst) begin
         oc_latch_r <= 1'b0;
      end else if (oc_fault && safety_r[SAF_OC_ON]) begin
         oc_latch_r <= 1'b1;
      end else if (!oc_s && !stat1_r[STAT1_OC]) begin
         oc_latch_r <= 1'b0;
      end
   end

   // Status flags; set wins over a clear in the same cycle
   always_comb begin
      set1 = {ot_s, oc_fault, sc_detect};
      set2 = {oc_diag, 3'h0, vbat_s, vg_ov_s, vg_uv_s, vcc_uv_s};
      clr1 = 8'h00;
      clr2 = 8'h00;
      if (reg_wr && reg_addr == ADDR_IRQ_STAT1) begin
         clr1 = reg_wdata & ~{ot_s, oc_s, 6'h00};
      end
      if (reg_wr && reg_addr == ADDR_IRQ_STAT2) begin
         clr2 = reg_wdata & ~set2;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         stat1_r <= RST_IRQ;
         stat2_r <= RST_IRQ;
      end else begin
         stat1_r <= (stat1_r & ~clr1) | set1;
         stat2_r <= ((stat2_r & ~clr2) | set2) & MASK_STAT2;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_n_r <= 1'b1;
      end else begin
         irq_n_r <= !(|((stat1_r & msk1_r) | (stat2_r & msk2_r)));
      end
   end

   // Configuration registers
   always_ff @(posedge clk_sys) begin
      if (cfg_rst) begin
         safety_r <= RST_SAFETY;
         scp_r <= RST_SCP;
         msk1_r <= RST_IRQ;
         msk2_r <= RST_IRQ;
         oc_thr_r <= RST_OC_THR;
         amon_r <= RST_AMON;
         oc_deb_r <= RST_OC_DEB;
         cal_r <= RST_CAL;
         trim_r <= RST_TRIM;
      end else if (reg_wr) begin
         unique case (reg_addr)
            ADDR_SAFETY: safety_r <= reg_wdata & MASK_SAFETY;
            ADDR_SCP: scp_r <= reg_wdata[1:0];
            ADDR_IRQ_MSK1: msk1_r <= reg_wdata;
            ADDR_IRQ_MSK2: msk2_r <= reg_wdata & MASK_STAT2;
            ADDR_OC_THR: oc_thr_r <= reg_wdata[5:0];
            ADDR_AMON: amon_r <= reg_wdata & MASK_AMON;
            ADDR_OC_DEB: oc_deb_r <= reg_wdata & MASK_OC_DEB;
            ADDR_CAL: cal_r <= reg_wdata[0];
            ADDR_TRIM: trim_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Ground codes collapse to one so the switch never sees an odd source
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         amon_eff_r <= AMON_GROUND;
      end else if (amon_r[3:0] >= AMON_FIRST_SRC && amon_r[3:0] <= AMON_LAST_SRC) begin
         amon_eff_r <= amon_r[3:0];
      end else begin
         amon_eff_r <= AMON_GROUND;
      end
   end

   // Read data
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ADDR_SAFETY: rdata_r <= safety_r;
            ADDR_SCP: rdata_r <= {6'h00, scp_r};
            ADDR_IRQ_MSK1: rdata_r <= msk1_r;
            ADDR_IRQ_STAT1: rdata_r <= stat1_r;
            ADDR_IRQ_MSK2: rdata_r <= msk2_r;
            ADDR_IRQ_STAT2: rdata_r <= stat2_r;
            ADDR_OC_THR: rdata_r <= {2'h0, oc_thr_r};
            ADDR_AMON: rdata_r <= amon_r;
            ADDR_OC_DEB: rdata_r <= oc_deb_r;
            ADDR_CAL: rdata_r <= {7'h00, cal_r};
            ADDR_TRIM: rdata_r <= trim_r;
            default: rdata_r <= 8'h00;
         endcase
      end
   end

   assign reg_rdata = rdata_r;
   assign hs_off = hs_off_r;
   assign ls_off = ls_off_r;
   assign mcu_reset = mcu_reset_r;
   assign regulators_off = reg_off_r;
   assign bus_disable = bus_dis_r;
   assign sleep_req = sleep_r;
   assign fault_irq_n = irq_n_r;
   assign amp_cal_select = cal_r;
   assign amp_inputs_gnd = cal_r;
   assign amp_offset_trim = trim_r;
   assign analog_monitor_select = amon_eff_r;
   assign analog_monitor_pin_buf_en = amon_r[AMON_BUF_EN];
   assign gate_uv_low_threshold = safety_r[SAF_GATE_UV_LOW];
   assign overcurrent_threshold = oc_thr_r;

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   logic quiet;
   logic [5:0] oc_run_r;
   assign quiet = !reg_wr && !fault_rst_r && !fault_now;
   always_ff @(posedge clk_sys) begin
      if (reset || !oc_s) begin
         oc_run_r <= 6'h00;
      end else if (oc_run_r != 6'h3F) begin
         oc_run_r <= oc_run_r + 6'h01;
      end
   end

   sc_code1_a: assert property (quiet && scp_r == 2'h1 && |sc_detect
      |-> ##2 hs_off && ls_off) else $error("code 1 did not hold drivers off");
   sc_code2_a: assert property (quiet && scp_r == 2'h2 && sc_cnt_r == 2'h0 && |sc_detect
      |=> !sc_hold && sc_cnt_r == 2'h1) else $error("code 2 gave no retry");
   sc_code3_a: assert property (quiet && scp_r == 2'h3 && sc_cnt_r == 2'h1 && |sc_detect
      |=> !sc_hold ##1 (sc_cnt_r != 2'h3 || ls_off))
      else $error("code 3 retry count wrong");
   sc_recount_a: assert property (!fault_rst_r && stat1_r[5:0] == 6'h00 && !(|sc_detect)
      |=> sc_cnt_r == 2'h0) else $error("retry count not restarted");
   cal_write_a: assert property (reg_wr && reg_addr == ADDR_CAL && !fault_rst_r
      |=> amp_cal_select == $past(reg_wdata[0])) else $error("cal bit not taken");
   cal_gnd_a: assert property (reg_wr && reg_addr == ADDR_CAL && !fault_rst_r
      |=> amp_inputs_gnd == $past(reg_wdata[0])) else $error("inputs not grounded");
   trim_write_a: assert property (reg_wr && reg_addr == ADDR_TRIM && !fault_rst_r
      |=> amp_offset_trim == $past(reg_wdata)) else $error("trim not taken");
   amon_map_a: assert property (!$stable(amon_r[3:0]) ##1 $stable(amon_r[3:0])
      |-> (amon_r[3:0] inside {[4'h2:4'hA]}) ? analog_monitor_select == amon_r[3:0]
                                             : analog_monitor_select == 4'h0)
      else $error("monitor source mapping wrong");
   buf_reset_a: assert property ($fell(fault_rst_r) |-> analog_monitor_pin_buf_en)
      else $error("buffer enable reset value");
   vbat_hs_a: assert property (safety_r[SAF_VBAT_OV_ON] && vbat_s |=> hs_off)
      else $error("high side not off on battery ov");
   vbat_ls_a: assert property (safety_r[SAF_VBAT_OV_ON] && vbat_s && !all_off |=> !ls_off)
      else $error("low side blocked on battery ov");
   gate_off_a: assert property (gate_block |=> hs_off && ls_off)
      else $error("gate supply fault left FETs on");
   logic_uv_a: assert property (vcc_uv_s |=> mcu_reset && ls_off && fault_rst_r)
      else $error("logic uv reaction missing");
   keep_stat_a: assert property (fault_rst_r && !(|set1) && !reg_wr |=> stat1_r == $past(stat1_r))
      else $error("status lost on fault reset");
   oc_hold_a: assert property (oc_latch_r && stat1_r[STAT1_OC] |=> ls_off && oc_latch_r)
      else $error("over-current released early");
   ot_code_a: assert property (ot_s && safety_r[1:0] == 2'h0 |=> bus_disable && !regulators_off)
      else $error("code 0 reaction wrong");
   wd_gate_a: assert property (wd_event && !wd_react_en && !wd_busy && !vcc_uv_s && !ot_s
      |=> !mcu_reset) else $error("watchdog reacted while disabled");
   wd_rst_a: assert property (wd_hit |=> mcu_reset [*8])
      else $error("watchdog reset too short");
   ot_sleep_a: assert property (ot_s && safety_r[SAF_SHUTDOWN_ON] |=> sleep_req && regulators_off)
      else $error("shutdown ignored");
   uv_sel_a: assert property ($fell(fault_rst_r) |-> !gate_uv_low_threshold)
      else $error("gate uv select reset value");
   thr_write_a: assert property (reg_wr && reg_addr == ADDR_OC_THR && !fault_rst_r
      |=> overcurrent_threshold == $past(reg_wdata[5:0])) else $error("threshold");
   oc_deb_a: assert property ($rose(oc_fault) && $stable(oc_lim)
      |-> oc_run_r >= 6'(oc_lim) && oc_run_r <= 6'(oc_lim) + 6'h1)
      else $error("over-current debounce length wrong");
   oc_diag_a: assert property ($rose(oc_diag) && $stable(oc_deb_r)
      |-> oc_run_r >= 6'(oc_deb_r[6:4]) && oc_run_r <= 6'(oc_deb_r[6:4]) + 6'h1)
      else $error("diagnostic debounce length wrong");
   clr_live_a: assert property (ot_s |=> stat1_r[STAT1_OT])
      else $error("flag cleared during failure");
   set_dis_a: assert property (!safety_r[SAF_GATE_ON] && vg_uv_s |=> stat2_r[STAT2_VG_UV])
      else $error("flag not set with reaction off");

   sc_hold_c: cover property (scp_r == 2'h2 && sc_hold);
   oc_trip_c: cover property ($rose(oc_latch_r) ##[1:200] $fell(oc_latch_r));
   wd_rst_c: cover property (wd_hit ##1 mcu_reset);
endmodule : gdfs_supervisor

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import gdfs_pkg::*;
   logic clk_sys, reset, reg_wr, reg_rd, oc, bov, guv, gov, luv, ot, wde, wden;
   logic hs, ls, mrst, regoff, busd, slp, irqn, cal, gnd, bufen, uvlo, ocf, ocd;
   logic [7:0] a, d, rdat, trim, q;
   logic [5:0] sc, thr;
   logic [3:0] amon;
   int bad_count, n_tests, cycles, k;
   logic [7:0] ra [5] = '{8'h16, 8'h17, 8'h1D, 8'h30, 8'h31};
   logic [7:0] rv [5] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'hA4};
   logic [7:0] rm [5] = '{8'h3F, 8'h9F, 8'h77, 8'h01, 8'hFF};
   gdfs_mcu_model u_mcu (.clk_sys(clk_sys), .reg_addr(a), .reg_wdata(d), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(rdat));
   gdfs_supervisor #(.MCU_RST_CYCLES(8)) u_dut (.clk_sys(clk_sys), .reset(reset),
      .reg_addr(a), .reg_wdata(d), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdat),
      .oc_cmp(oc), .battery_ov_cmp(bov), .gate_uv_cmp(guv), .gate_ov_cmp(gov),
      .logic_uv_cmp(luv), .overtemp_cmp(ot), .sc_detect(sc), .wd_event(wde),
      .wd_react_en(wden), .hs_off(hs), .ls_off(ls), .mcu_reset(mrst),
      .regulators_off(regoff), .bus_disable(busd), .sleep_req(slp), .fault_irq_n(irqn),
      .amp_cal_select(cal), .amp_inputs_gnd(gnd), .amp_offset_trim(trim),
      .analog_monitor_select(amon), .analog_monitor_pin_buf_en(bufen), .gate_uv_low_threshold(uvlo),
      .overcurrent_threshold(thr), .oc_fault(ocf), .oc_diag(ocd));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report
   // Bound well above the roughly 400 cycles the sequence needs
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         final_report();
      end
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] ad, input logic [7:0] e);
      u_mcu.rd(ad, q);
      chk($sformatf("reg %h", ad), e, q);
   endtask : rdchk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc
   task automatic pulse_sc;
      @(negedge clk_sys);
      sc = 6'h01;
      @(negedge clk_sys);
      sc = 6'h00;
      cyc(3);
   endtask : pulse_sc
   initial begin
      {reset, oc, bov, guv, gov, luv, ot, wde, wden, sc} = {1'b1, 14'h0000};
      cyc(8);
      reset = 1'b0;
      cyc(2);
      rdchk(ADDR_SAFETY, 8'h1E);
      for (k = 0; k < 5; k++) rdchk(ra[k], rv[k]);
      rdchk(8'h40, 8'h00);
      chk("trim", 8'hA4, trim);
      chk("buf", 8'h01, {7'h00, bufen});
      for (k = 0; k < 5; k++) u_mcu.wr(ra[k], 8'hFF);
      for (k = 0; k < 5; k++) rdchk(ra[k], rm[k]);
      chk("thr", 8'h3F, {2'h0, thr});
      chk("cal", 8'h03, {6'h00, cal, gnd});
      u_mcu.wr(ADDR_SAFETY, 8'h3F);
      chk("uvlo", 8'h01, {7'h00, uvlo});
      u_mcu.wr(ADDR_SAFETY, 8'h1E);
      u_mcu.wr(ADDR_AMON, 8'h00);
      chk("buf", 8'h00, {7'h00, bufen});
      for (k = 0; k < 16; k++) begin
         u_mcu.wr(ADDR_AMON, 8'h80 | k[7:0]);
         cyc(2);
         chk("amon", (k >= 2 && k <= 10) ? k[7:0] : 8'h00, {4'h0, amon});
      end
      u_mcu.calibrate(8'h5A);
      chk("cal", {6'h00, 2'b00}, {6'h00, cal, gnd});
      chk("trim", 8'h5A, trim);
      u_mcu.wr(ADDR_OC_THR, 8'h00);
      $display("test registers done");
      u_mcu.wr(ADDR_IRQ_MSK2, 8'h08);
      bov = 1'b1;
      cyc(6);
      chk("bov", 8'h02, {6'h00, hs, ls});
      chk("irqn", 8'h00, {7'h00, irqn});
      u_mcu.wr(ADDR_IRQ_STAT2, 8'h08);
      rdchk(ADDR_IRQ_STAT2, 8'h08);
      bov = 1'b0;
      cyc(6);
      chk("bov", 8'h00, {6'h00, hs, ls});
      u_mcu.wr(ADDR_IRQ_STAT2, 8'h08);
      rdchk(ADDR_IRQ_STAT2, 8'h00);
      cyc(2);
      chk("irqn", 8'h01, {7'h00, irqn});
      guv = 1'b1;
      cyc(6);
      chk("guv", 8'h03, {6'h00, hs, ls});
      guv = 1'b0;
      cyc(6);
      chk("guv", 8'h00, {6'h00, hs, ls});
      u_mcu.wr(ADDR_SAFETY, 8'h1A);
      u_mcu.wr(ADDR_IRQ_STAT2, 8'h02);
      guv = 1'b1;
      cyc(6);
      chk("guv off", 8'h00, {6'h00, hs, ls});
      rdchk(ADDR_IRQ_STAT2, 8'h02);
      guv = 1'b0;
      cyc(6);
      u_mcu.wr(ADDR_IRQ_STAT2, 8'h02);
      u_mcu.wr(ADDR_SAFETY, 8'h1E);
      $display("test supplies done");
      for (k = 1; k < 4; k++) begin
         u_mcu.wr(ADDR_SCP, k[7:0]);
         repeat (k - 1) pulse_sc();
         chk("retry", 8'h00, {6'h00, hs, ls});
         pulse_sc();
         chk("hold", 8'h03, {6'h00, hs, ls});
         u_mcu.wr(ADDR_IRQ_STAT1, 8'h3F);
         cyc(3);
         chk("release", 8'h00, {6'h00, hs, ls});
      end
      $display("test short circuit done");
      u_mcu.wr(ADDR_OC_DEB, 8'h02);
      oc = 1'b1;
      for (k = 1; k < 40 && ocf !== 1'b1; k++) cyc(1);
      chk("oc_debounce_count", 8'h01, {7'h00, k >= 10 && k <= 13});
      chk("diag", 8'h01, {7'h00, ocd});
      cyc(3);
      chk("oc", 8'h03, {6'h00, hs, ls});
      rdchk(ADDR_IRQ_STAT1, 8'h40);
      oc = 1'b0;
      cyc(6);
      chk("oc latch", 8'h03, {6'h00, hs, ls});
      u_mcu.wr(ADDR_IRQ_STAT1, 8'h40);
      u_mcu.wr(ADDR_IRQ_STAT2, 8'h80);
      cyc(3);
      chk("oc free", 8'h00, {6'h00, hs, ls});
      $display("test over-current done");
      u_mcu.wr(ADDR_TRIM, 8'h33);
      bov = 1'b1;
      cyc(6);
      bov = 1'b0;
      wde = 1'b1;
      cyc(1);
      wde = 1'b0;
      cyc(5);
      chk("wd off", 8'h00, {7'h00, mrst});
      wden = 1'b1;
      wde = 1'b1;
      cyc(1);
      wde = 1'b0;
      cyc(2);
      chk("wd", 8'h01, {7'h00, mrst});
      cyc(20);
      chk("wd end", 8'h00, {7'h00, mrst});
      rdchk(ADDR_TRIM, 8'hA4);
      rdchk(ADDR_IRQ_STAT2, 8'h08);
      $display("test watchdog done");
      u_mcu.wr(ADDR_TRIM, 8'h33);
      luv = 1'b1;
      cyc(6);
      chk("luv", 8'h07, {5'h00, hs, ls, mrst});
      luv = 1'b0;
      cyc(6);
      rdchk(ADDR_TRIM, 8'hA4);
      gov = 1'b1;
      cyc(6);
      chk("gov", 8'h03, {6'h00, hs, ls});
      gov = 1'b0;
      cyc(6);
      rdchk(ADDR_IRQ_STAT2, 8'h0D);
      $display("test supply resets done");
      ot = 1'b1;
      cyc(6);
      chk("ot2", 8'h3E, {2'h0, hs, ls, busd, regoff, mrst, slp});
      ot = 1'b0;
      cyc(6);
      chk("ot end", 8'h00, {2'h0, hs, ls, busd, regoff, mrst, slp});
      rdchk(ADDR_IRQ_STAT1, 8'h80);
      u_mcu.wr(ADDR_IRQ_STAT1, 8'h80);
      u_mcu.wr(ADDR_SAFETY, 8'h1C);
      ot = 1'b1;
      cyc(6);
      chk("ot0", 8'h38, {2'h0, hs, ls, busd, regoff, mrst, slp});
      ot = 1'b0;
      cyc(6);
      u_mcu.wr(ADDR_IRQ_STAT1, 8'h80);
      u_mcu.wr(ADDR_SAFETY, 8'h1D);
      ot = 1'b1;
      for (k = 0; k < 8 && slp !== 1'b1; k++) cyc(1);
      chk("ot1", 8'h03, {6'h00, regoff, slp});
      ot = 1'b0;
      cyc(6);
      u_mcu.wr(ADDR_IRQ_STAT1, 8'h80);
      $display("test overtemperature done");
      final_report();
   end
endmodule : tb_top
